// ==== hw/perf_evt_defs.vh ====
// Event codes, widths and reset values for the performance event qualifier
`ifndef PERF_EVT_DEFS_VH
`define PERF_EVT_DEFS_VH

// Width of the event select code
`define EVT_W            6
// Event codes handled by this block
`define EVT_RD_STALL     6'h1a
`define EVT_WR_EM_STALL  6'h1b
`define EVT_LOCKED_BUS   6'h1c
`define EVT_IO_CYCLE     6'h1d
`define EVT_NC_READ      6'h1e
`define EVT_AGI_STALL    6'h1f
`define EVT_RSVD_0       6'h20
`define EVT_RSVD_1       6'h21
`define EVT_FLOAT_OP     6'h22
`define EVT_BP_MATCH_0   6'h23
`define EVT_BP_MATCH_1   6'h24
`define EVT_BP_MATCH_2   6'h25
`define EVT_BP_MATCH_3   6'h26

// Increment width: at most two occurrences per clock
`define INC_W            2
`define INC_ZERO         2'h0
`define INC_ONE          2'h1
// Number of debug address registers
`define BP_N             4
`define BP_RST           4'h0
// Bit positions in the excluded float exception vector
`define FX_DIV_ZERO      0
`define FX_NEG_SQRT      1
`define FX_SPECIAL_OPND  2
`define FX_STACK         3
`define FX_W             4
`define FX_NONE          4'h0

`endif

// ==== hw/agi_detect.v ====
// Address-generation interlock detector for one address-generation stage slot
`timescale 1ns/1ps
`default_nettype none

module agi_detect #(
  parameter REG_W = 3
) (
  // Execute stage writers, primary and secondary pipes
  input  wire             ex_u_wr_i,
  input  wire [REG_W-1:0] ex_u_dst_i,
  input  wire             ex_v_wr_i,
  input  wire [REG_W-1:0] ex_v_dst_i,
  // Address-generation stage operands of this slot
  input  wire             ag_valid_i,
  input  wire             ag_base_used_i,
  input  wire [REG_W-1:0] ag_base_i,
  input  wire             ag_idx_used_i,
  input  wire [REG_W-1:0] ag_idx_i,
  // Interlock flag
  output wire             interlock_o
);

  wire hit_u;
  wire hit_v;

  // Either execute-stage writer may hit base or index of this slot
  assign hit_u = ex_u_wr_i && ((ag_base_used_i && (ag_base_i == ex_u_dst_i)) ||
                               (ag_idx_used_i && (ag_idx_i == ex_u_dst_i)));
  assign hit_v = ex_v_wr_i && ((ag_base_used_i && (ag_base_i == ex_v_dst_i)) ||
                               (ag_idx_used_i && (ag_idx_i == ex_v_dst_i)));

  // One stall per stalled slot, however many writers collide
  assign interlock_o = ag_valid_i && (hit_u || hit_v);

endmodule

`default_nettype wire

// ==== hw/bp_match_qual.v ====
// Breakpoint match qualification for the four debug address registers
`timescale 1ns/1ps
`default_nettype none

module bp_match_qual #(
  parameter BP_N = 4
) (
  // Raw comparator results per register and pipe
  input  wire [BP_N-1:0] match_u_i,
  input  wire [BP_N-1:0] match_v_i,
  // Register is a code breakpoint
  input  wire [BP_N-1:0] is_code_i,
  // Breakpoints enabled by software
  input  wire [BP_N-1:0] enabled_i,
  // Qualified match per register
  output wire [BP_N-1:0] match_o
);

  genvar i;

  // Disabled code breakpoints are checked in the primary pipe only;
  // enable state otherwise does not gate the match
  generate
    for (i = 0; i < BP_N; i = i + 1) begin : g_bp
      assign match_o[i] = match_u_i[i] ||
                          (match_v_i[i] && (enabled_i[i] || !is_code_i[i]));
    end
  endgenerate

endmodule

`default_nettype wire

// ==== hw/perf_event_select_decode.v ====
// Performance event qualifier for event codes 1a to 26 feeding one counter
//
// Behaviour
// - Code 1a: one per clock stalled on data read, data TLB miss included.
// - Code 1a also counts reads held off while a line fill runs.
// - Code 1b: one per stall on write to exclusive or modified line.
// - Code 1c: locked bus cycles from lock prefix, page and descriptor updates.
// - Code 1c counts the read of a locked read-modify-write, not the write.
// - Split locked access under split cycle flag counts as two accesses.
// - Codes 1c, 1d, 1e skip bus cycles restarted after back-off.
// - Code 1d: I/O bus cycles; misaligned I/O gives two cycles, adds two.
// - Code 1e: noncacheable memory read cycles, TLB misses in, I/O out.
// - Code 1f: interlock stalls, two when both pipes stall together.
// - Interlock: execute stage writes base or index of address-gen stage.
// - Code 22: float add, sub, mul, div, remainder, square root.
// - Transcendentals count once per internal add or multiply.
// - Zero-divide, negative root, special operand, stack faults are not counted.
// - Integer multiply and other float-unit instructions also count.
// - Codes 23 to 26 count matches on debug address registers 0 to 3.
// - Breakpoint matches count enabled or not, except disabled code breakpoints matching in the secondary pipe.
// - Match events equal the breakpoint match pin indications.
`timescale 1ns/1ps
`default_nettype none
`include "perf_evt_defs.vh"

module perf_event_select_decode #(
  parameter REG_W = 3
) (
  // Clock and reset
  input  wire                sys_clk_i,
  input  wire                srst_i,

  // Counter event select
  input  wire [`EVT_W-1:0]   evt_sel_i,

  // Data read stall sources
  input  wire                rd_stall_i,
  input  wire                dtlb_miss_busy_i,
  input  wire                fill_block_rd_i,

  // Write stall on exclusive or modified line, level while stalled
  input  wire                wr_em_stall_i,

  // Bus unit cycle start and attributes
  input  wire                bus_cyc_start_i,
  input  wire                bus_cyc_busy_i,
  input  wire                bus_cyc_lock_i,
  input  wire                bus_cyc_wr_i,
  input  wire                bus_cyc_io_i,
  input  wire                bus_cyc_ncache_i,
  input  wire                split_cycle_flag_i,
  input  wire                bus_backoff_input_n_i,

  // Execute stage writers
  input  wire                ex_u_wr_i,
  input  wire [REG_W-1:0]    ex_u_dst_i,
  input  wire                ex_v_wr_i,
  input  wire [REG_W-1:0]    ex_v_dst_i,

  // Primary pipe address-generation stage
  input  wire                ag_u_valid_i,
  input  wire                ag_u_base_used_i,
  input  wire [REG_W-1:0]    ag_u_base_i,
  input  wire                ag_u_idx_used_i,
  input  wire [REG_W-1:0]    ag_u_idx_i,

  // Secondary pipe address-generation stage
  input  wire                ag_v_valid_i,
  input  wire                ag_v_base_used_i,
  input  wire [REG_W-1:0]    ag_v_base_i,
  input  wire                ag_v_idx_used_i,
  input  wire [REG_W-1:0]    ag_v_idx_i,

  // Floating-point unit
  input  wire                fp_op_i,
  input  wire [`FX_W-1:0]    fp_xcpt_i,
  input  wire                fpu_other_op_i,

  // Breakpoint comparators
  input  wire [`BP_N-1:0]    bp_match_u_i,
  input  wire [`BP_N-1:0]    bp_match_v_i,
  input  wire [`BP_N-1:0]    bp_is_code_i,
  input  wire [`BP_N-1:0]    bp_enabled_i,

  // Counter increment and breakpoint pins
  output reg  [`INC_W-1:0]   cnt_inc_o,
  output reg  [`BP_N-1:0]    breakpoint_match_pins_o
);

  // Interlock flags per address-generation slot
  wire                       agi_u;
  wire                       agi_v;
  // Qualified breakpoint matches
  wire [`BP_N-1:0]           bp_match;

  // Previous write-stall level, for stall start detection
  reg                        wr_em_prev_r;
  // A back-off hit the running bus cycle; its restart is not new
  reg                        restart_pend_r;
  reg                        restart_pend_nxt;

  // Per-event occurrence counts for this clock
  reg  [`INC_W-1:0]          n_rd_stall;
  reg  [`INC_W-1:0]          n_wr_stall;
  reg  [`INC_W-1:0]          n_locked;
  reg  [`INC_W-1:0]          n_io;
  reg  [`INC_W-1:0]          n_nc_rd;
  reg  [`INC_W-1:0]          n_agi;
  reg  [`INC_W-1:0]          n_fp;
  reg  [`INC_W-1:0]          inc_nxt;

  wire                       backoff_now;
  wire                       new_cycle;
  wire                       fp_counted;

  // Interlock in the primary pipe's address-generation slot
  agi_detect #(
    .REG_W          (REG_W)
  ) u_agi_u (
    .ex_u_wr_i      (ex_u_wr_i),
    .ex_u_dst_i     (ex_u_dst_i),
    .ex_v_wr_i      (ex_v_wr_i),
    .ex_v_dst_i     (ex_v_dst_i),
    .ag_valid_i     (ag_u_valid_i),
    .ag_base_used_i (ag_u_base_used_i),
    .ag_base_i      (ag_u_base_i),
    .ag_idx_used_i  (ag_u_idx_used_i),
    .ag_idx_i       (ag_u_idx_i),
    .interlock_o    (agi_u)
  );

  // Interlock in the secondary pipe's address-generation slot
  agi_detect #(
    .REG_W          (REG_W)
  ) u_agi_v (
    .ex_u_wr_i      (ex_u_wr_i),
    .ex_u_dst_i     (ex_u_dst_i),
    .ex_v_wr_i      (ex_v_wr_i),
    .ex_v_dst_i     (ex_v_dst_i),
    .ag_valid_i     (ag_v_valid_i),
    .ag_base_used_i (ag_v_base_used_i),
    .ag_base_i      (ag_v_base_i),
    .ag_idx_used_i  (ag_v_idx_used_i),
    .ag_idx_i       (ag_v_idx_i),
    .interlock_o    (agi_v)
  );

  // Breakpoint match qualification
  bp_match_qual #(
    .BP_N       (`BP_N)
  ) u_bp_qual (
    .match_u_i  (bp_match_u_i),
    .match_v_i  (bp_match_v_i),
    .is_code_i  (bp_is_code_i),
    .enabled_i  (bp_enabled_i),
    .match_o    (bp_match)
  );

  // Back-off pin is active low; it only matters while a cycle runs
  assign backoff_now = !bus_backoff_input_n_i && bus_cyc_busy_i;

  // A start that follows a back-off is the same cycle again
  assign new_cycle = bus_cyc_start_i && !restart_pend_r;

  // Restart tracking: a back-off in the start clock itself arms again,
  // so that the set is never lost to the clear
  always @* begin
    restart_pend_nxt = restart_pend_r;
    if (bus_cyc_start_i) begin
      restart_pend_nxt = 1'b0;
    end
    if (backoff_now) begin
      restart_pend_nxt = 1'b1;
    end
  end

  // Float operations with one of the four excluded faults drop out
  assign fp_counted = fp_op_i && (fp_xcpt_i == `FX_NONE);

  // Occurrence counts per event in this clock
  always @* begin
    // Read stall clocks, including TLB misses and fill-blocked reads
    n_rd_stall = (rd_stall_i || dtlb_miss_busy_i || fill_block_rd_i) ?
                 `INC_ONE : `INC_ZERO;
    // One per stall, taken at the stall's first clock
    n_wr_stall = (wr_em_stall_i && !wr_em_prev_r) ?
                 `INC_ONE : `INC_ZERO;
    // Locked read cycles only; each half of a split access has its own start
    n_locked   = (new_cycle && bus_cyc_lock_i && !bus_cyc_wr_i) ?
                 `INC_ONE : `INC_ZERO;
    // Every I/O cycle, so a misaligned access adds two over two starts
    n_io       = (new_cycle && bus_cyc_io_i) ?
                 `INC_ONE : `INC_ZERO;
    // Noncacheable memory reads, I/O space excluded
    n_nc_rd    = (new_cycle && bus_cyc_ncache_i && !bus_cyc_wr_i && !bus_cyc_io_i) ?
                 `INC_ONE : `INC_ZERO;
    // Both pipes interlocked in one clock count twice
    n_agi      = {1'b0, agi_u} + {1'b0, agi_v};
    // Internal float steps and other float-unit work, both per clock
    n_fp       = {1'b0, fp_counted} + {1'b0, fpu_other_op_i};
  end

  // Select the increment for the chosen event
  always @* begin
    case (evt_sel_i)
      `EVT_RD_STALL: begin
        inc_nxt = n_rd_stall;
      end
      `EVT_WR_EM_STALL: begin
        inc_nxt = n_wr_stall;
      end
      `EVT_LOCKED_BUS: begin
        inc_nxt = n_locked;
      end
      `EVT_IO_CYCLE: begin
        inc_nxt = n_io;
      end
      `EVT_NC_READ: begin
        inc_nxt = n_nc_rd;
      end
      `EVT_AGI_STALL: begin
        inc_nxt = n_agi;
      end
      `EVT_RSVD_0, `EVT_RSVD_1: begin
        inc_nxt = `INC_ZERO;
      end
      `EVT_FLOAT_OP: begin
        inc_nxt = n_fp;
      end
      // Breakpoint events read the very vector that drives the pins
      `EVT_BP_MATCH_0: begin
        inc_nxt = {1'b0, bp_match[0]};
      end
      `EVT_BP_MATCH_1: begin
        inc_nxt = {1'b0, bp_match[1]};
      end
      `EVT_BP_MATCH_2: begin
        inc_nxt = {1'b0, bp_match[2]};
      end
      `EVT_BP_MATCH_3: begin
        inc_nxt = {1'b0, bp_match[3]};
      end
      // Codes outside this block belong to other qualifiers
      default: begin
        inc_nxt = `INC_ZERO;
      end
    endcase
  end

  // Registered outputs and history; one clock of latency keeps the
  // increment and the pins aligned on the same edge
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_inc_o               <= `INC_ZERO;
      breakpoint_match_pins_o <= `BP_RST;
      wr_em_prev_r            <= 1'b0;
      restart_pend_r          <= 1'b0;
    end else begin
      cnt_inc_o               <= inc_nxt;
      breakpoint_match_pins_o <= bp_match;
      wr_em_prev_r            <= wr_em_stall_i;
      restart_pend_r          <= restart_pend_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== verification/perf_evt_checker.sv ====
// Checker watching the performance event qualifier ports
`timescale 1ns/1ps
`default_nettype none
`include "perf_evt_defs.vh"
module perf_evt_checker (
  // Clock, reset and select
  input wire logic              sys_clk_i, srst_i,
  input wire logic [`EVT_W-1:0] evt_sel_i,
  // Event sources
  input wire logic              rd_stall_i, dtlb_miss_busy_i, fill_block_rd_i, wr_em_stall_i,
  input wire logic              bus_cyc_start_i, bus_cyc_busy_i, bus_cyc_lock_i, bus_cyc_wr_i,
  input wire logic              bus_cyc_io_i, bus_cyc_ncache_i, bus_backoff_input_n_i,
  input wire logic              fp_op_i, fpu_other_op_i,
  input wire logic [3:0]        fp_xcpt_i, bp_match_u_i,
  // Outputs
  input wire logic [1:0]        cnt_inc_o,
  input wire logic [3:0]        breakpoint_match_pins_o
);
  logic pend_r;
  // A back-off inside a cycle makes the next start a restart; set wins over clear
  always_ff @(posedge sys_clk_i)
    if (srst_i) pend_r <= 1'b0;
    else if (bus_cyc_busy_i && !bus_backoff_input_n_i) pend_r <= 1'b1;
    else if (bus_cyc_start_i) pend_r <= 1'b0;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_bus_backoff_input;
    bus_cyc_busy_i && !bus_backoff_input_n_i && !bus_cyc_start_i;
  endsequence
  sequence s_new(logic [5:0] c);
    evt_sel_i == c && bus_cyc_start_i && !pend_r;
  endsequence

  a_rd_stall_clock: assert property (evt_sel_i == `EVT_RD_STALL |=>
    cnt_inc_o == {1'b0, $past(rd_stall_i | dtlb_miss_busy_i | fill_block_rd_i)}) else $error("read stall count");
  a_wr_stall_rise: assert property (evt_sel_i == `EVT_WR_EM_STALL && $rose(wr_em_stall_i) |=>
    cnt_inc_o == 2'h1) else $error("write stall not counted");
  a_wr_stall_level: assert property (evt_sel_i == `EVT_WR_EM_STALL && wr_em_stall_i ##1
    evt_sel_i == `EVT_WR_EM_STALL && wr_em_stall_i |=> cnt_inc_o == 2'h0) else $error("write stall recounted");
  a_locked_read: assert property (s_new(`EVT_LOCKED_BUS) |=>
    cnt_inc_o == {1'b0, $past(bus_cyc_lock_i && !bus_cyc_wr_i)}) else $error("locked cycle count");
  a_io_cycle: assert property (s_new(`EVT_IO_CYCLE) |=>
    cnt_inc_o == {1'b0, $past(bus_cyc_io_i)}) else $error("io cycle count");
  a_ncache_read: assert property (s_new(`EVT_NC_READ) |=>
    cnt_inc_o == {1'b0, $past(bus_cyc_ncache_i && !bus_cyc_wr_i && !bus_cyc_io_i)}) else $error("nc read count");
  a_restart_skip: assert property (s_bus_backoff_input ##1 bus_cyc_start_i && evt_sel_i inside {[6'h1c:6'h1e]} |=>
    cnt_inc_o == 2'h0) else $error("restarted cycle counted");
  a_reserved_zero: assert property (!(evt_sel_i inside {[6'h1a:6'h1f], [6'h22:6'h26]}) |=>
    cnt_inc_o == 2'h0) else $error("reserved code counted");
  a_float_count: assert property (evt_sel_i == `EVT_FLOAT_OP |=> cnt_inc_o ==
    {1'b0, $past(fp_op_i && fp_xcpt_i == 4'h0)} + {1'b0, $past(fpu_other_op_i)}) else $error("float count");
  a_bp_pin_event: assert property (evt_sel_i inside {[6'h23:6'h26]} |=>
    cnt_inc_o == {1'b0, breakpoint_match_pins_o[$past(evt_sel_i) - 6'h23]}) else $error("bp event vs pin");
  a_bp_primary: assert property (bp_match_u_i != 4'h0 |=>
    (breakpoint_match_pins_o & $past(bp_match_u_i)) == $past(bp_match_u_i)) else $error("primary bp lost");
endmodule
bind perf_event_select_decode perf_evt_checker i_chk (.*);
`default_nettype wire

// ==== verification/bus_unit_model.sv ====
// Bus unit model: bus cycles with attributes, split halves and back-off
`timescale 1ns/1ps
`default_nettype none
module bus_unit_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Request from the bench
  input  wire logic       req_i,
  input  wire logic       two_i,
  input  wire logic       bus_backoff_input_i,
  input  wire logic [3:0] attr_i,
  // Toward the qualifier
  output logic            start_o,
  output logic            busy_o,
  output logic            bus_backoff_input_n_o,
  output logic [3:0]      attr_o
);
  logic [1:0] p_r;
  logic [1:0] n_r;
  logic       b_r;
  logic [3:0] attr_r;
  // Phase 1 starts a cycle, phase 2 ends it or reruns it after back-off
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      p_r    <= 2'h0;
      n_r    <= 2'h0;
      b_r    <= 1'b0;
      attr_r <= 4'h0;
    end else if (req_i && p_r == 2'h0) begin
      p_r    <= 2'h1;
      n_r    <= two_i ? 2'h2 : 2'h1;
      b_r    <= bus_backoff_input_i;
      attr_r <= attr_i;
    end else if (p_r == 2'h2) begin
      p_r <= (b_r || n_r > 2'h1) ? 2'h1 : 2'h0;
      n_r <= b_r ? n_r : n_r - 2'h1;
      b_r <= 1'b0;
    end else if (p_r == 2'h1)
      p_r <= 2'h2;
  end
  // Attributes are valid only with the start; otherwise they show garbage
  assign start_o  = (p_r == 2'h1);
  assign busy_o   = (p_r != 2'h0);
  assign bus_backoff_input_n_o = !(p_r == 2'h2 && b_r);
  assign attr_o   = start_o ? attr_r : ~attr_r;
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the performance event qualifier
`timescale 1ns/1ps
`default_nettype none
`include "perf_evt_defs.vh"
module testbench;
  // Design signals, named as the ports
  logic sys_clk_i, srst_i, rd_stall_i, dtlb_miss_busy_i, fill_block_rd_i, wr_em_stall_i;
  logic split_cycle_flag_i, ex_u_wr_i, ex_v_wr_i, ag_u_valid_i, ag_u_base_used_i, ag_u_idx_used_i;
  logic ag_v_valid_i, ag_v_base_used_i, ag_v_idx_used_i, fp_op_i, fpu_other_op_i, req, two, bus_backoff_input;
  logic [2:0] ex_u_dst_i, ex_v_dst_i, ag_u_base_i, ag_u_idx_i, ag_v_base_i, ag_v_idx_i;
  logic [3:0] fp_xcpt_i, bp_match_u_i, bp_match_v_i, bp_is_code_i, bp_enabled_i, attr;
  logic [`EVT_W-1:0] evt_sel_i;
  wire logic bus_cyc_start_i, bus_cyc_busy_i, bus_cyc_lock_i, bus_cyc_wr_i, bus_cyc_io_i;
  wire logic bus_cyc_ncache_i, bus_backoff_input_n_i;
  wire logic [`INC_W-1:0] cnt_inc_o;
  wire logic [`BP_N-1:0] breakpoint_match_pins_o;
  int num_errors = 0;
  int total_checks = 0;

  perf_event_select_decode #(.REG_W(3)) i_dut (.*);
  bus_unit_model i_bus (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req), .two_i(two), .bus_backoff_input_i(bus_backoff_input),
    .attr_i(attr), .start_o(bus_cyc_start_i), .busy_o(bus_cyc_busy_i), .bus_backoff_input_n_o(bus_backoff_input_n_i),
    .attr_o({bus_cyc_lock_i, bus_cyc_wr_i, bus_cyc_io_i, bus_cyc_ncache_i}));

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // All event sources quiet; the select is left alone
  task automatic idle;
    {rd_stall_i, dtlb_miss_busy_i, fill_block_rd_i, wr_em_stall_i, fp_op_i, fpu_other_op_i} <= '0;
    {ex_u_wr_i, ex_u_dst_i, ex_v_wr_i, ex_v_dst_i, fp_xcpt_i, bp_is_code_i, bp_enabled_i} <= '0;
    {ag_u_valid_i, ag_u_base_used_i, ag_u_base_i, ag_u_idx_used_i, ag_u_idx_i} <= '0;
    {ag_v_valid_i, ag_v_base_used_i, ag_v_base_i, ag_v_idx_used_i, ag_v_idx_i} <= '0;
    {bp_match_u_i, bp_match_v_i, req, two, bus_backoff_input, attr, split_cycle_flag_i} <= '0;
  endtask
  // Sample the applied sources for one clock, then judge both outputs
  task automatic expect_inc(input logic [1:0] exp, input logic [3:0] pins);
    @(posedge sys_clk_i);
    idle();
    #1;
    chk({2'h0, cnt_inc_o}, {2'h0, exp});
    chk(breakpoint_match_pins_o, pins);
  endtask
  task automatic bus(input logic [5:0] evt, input logic [3:0] at, input logic tw, input logic bo,
                     input logic [3:0] exp);
    logic [3:0] sum;
    sum = 4'h0;
    @(posedge sys_clk_i);
    {evt_sel_i, attr, two, split_cycle_flag_i, bus_backoff_input, req} <= {evt, at, tw, tw, bo, 1'b1};
    @(posedge sys_clk_i);
    req <= 1'b0;
    repeat (8) begin
      @(posedge sys_clk_i);
      #1 sum = sum + {2'h0, cnt_inc_o};
    end
    chk(sum, exp);
  endtask
  task automatic agi(input logic [7:0] ex, input logic [8:0] u, input logic [8:0] v, input logic [1:0] exp);
    @(posedge sys_clk_i);
    evt_sel_i <= `EVT_AGI_STALL;
    {ex_u_wr_i, ex_u_dst_i, ex_v_wr_i, ex_v_dst_i} <= ex;
    {ag_u_valid_i, ag_u_base_used_i, ag_u_base_i, ag_u_idx_used_i, ag_u_idx_i} <= u;
    {ag_v_valid_i, ag_v_base_used_i, ag_v_base_i, ag_v_idx_used_i, ag_v_idx_i} <= v;
    expect_inc(exp, 4'h0);
  endtask
  task automatic fp(input logic [5:0] x, input logic [1:0] exp);
    @(posedge sys_clk_i);
    evt_sel_i <= `EVT_FLOAT_OP;
    {fp_op_i, fpu_other_op_i, fp_xcpt_i} <= x;
    expect_inc(exp, 4'h0);
  endtask
  task automatic bp(input logic [5:0] evt, input logic [15:0] m, input logic [1:0] exp, input logic [3:0] p);
    @(posedge sys_clk_i);
    evt_sel_i <= evt;
    {bp_match_u_i, bp_match_v_i, bp_is_code_i, bp_enabled_i} <= m;
    expect_inc(exp, p);
  endtask
  task automatic t_misc;
    logic [5:0] codes [4] = '{6'h20, 6'h21, 6'h19, 6'h27};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      evt_sel_i <= `EVT_RD_STALL;
      {rd_stall_i, dtlb_miss_busy_i, fill_block_rd_i} <= 3'h1 << i;
      expect_inc({1'b0, i < 3}, 4'h0);
      @(posedge sys_clk_i);
      evt_sel_i <= codes[i];
      {rd_stall_i, wr_em_stall_i, fp_op_i, fpu_other_op_i, bp_match_u_i} <= 8'hff;
      expect_inc(2'h0, 4'hf);
    end
    // A held write stall is one stall, however long it lasts
    @(posedge sys_clk_i);
    evt_sel_i <= `EVT_WR_EM_STALL;
    wr_em_stall_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i);
      #1 chk({2'h0, cnt_inc_o}, {3'h0, i == 0});
    end
    expect_inc(2'h0, 4'h0);
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    logic [3:0] b;
    srst_i = 1'b1;
    evt_sel_i = 6'h00;
    idle();
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_misc();
    $display("stall and reserved tests done");
    bus(`EVT_LOCKED_BUS, 4'h8, 1'b0, 1'b0, 4'h1);
    bus(`EVT_LOCKED_BUS, 4'hc, 1'b0, 1'b0, 4'h0);
    bus(`EVT_LOCKED_BUS, 4'h8, 1'b1, 1'b0, 4'h2);
    bus(`EVT_LOCKED_BUS, 4'h8, 1'b0, 1'b1, 4'h1);
    bus(`EVT_IO_CYCLE, 4'h2, 1'b1, 1'b1, 4'h2);
    bus(`EVT_NC_READ, 4'h1, 1'b0, 1'b1, 4'h1);
    bus(`EVT_NC_READ, 4'h3, 1'b0, 1'b0, 4'h0);
    bus(`EVT_NC_READ, 4'h5, 1'b0, 1'b0, 4'h0);
    $display("bus cycle tests done");
    agi(8'hb0, 9'h1b0, 9'h000, 2'h1);
    agi(8'hb0, 9'h1b0, 9'h10b, 2'h2);
    agi(8'h0d, 9'h150, 9'h10d, 2'h1);
    agi(8'h0d, 9'h150, 9'h00d, 2'h0);
    $display("interlock tests done");
    fp(6'h20, 2'h1);
    for (int i = 0; i < 4; i++) fp(6'h20 | (6'h1 << i), 2'h0);
    fp(6'h30, 2'h2);
    fp(6'h10, 2'h1);
    @(posedge sys_clk_i);
    fp_op_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 chk({2'h0, cnt_inc_o}, 4'h1);
    expect_inc(2'h1, 4'h0);
    $display("float tests done");
    for (int i = 0; i < 4; i++) begin
      b = 4'h1 << i;
      bp(6'(6'h23 + i), {4'h0, b, b, 4'h0}, 2'h0, 4'h0);
      bp(6'(6'h23 + i), {4'h0, b, b, b}, 2'h1, b);
      bp(6'(6'h23 + i), {b, 4'h0, b, 4'h0}, 2'h1, b);
      bp(6'(6'h23 + i), {4'h0, b, 8'h0}, 2'h1, b);
      bp(6'(6'h23 + (i + 1) % 4), {b, 12'h0}, 2'h0, b);
    end
    $display("breakpoint tests done");
    results();
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule
`default_nettype wire
